// file: rtl/rss_pkg.sv
// Shared constants for the rail strobe sequencer configuration block
package rss_pkg;
    // Register subaddresses
    localparam logic [7:0] ADDR_DELAY_FACTOR = 8'h21;
    localparam logic [7:0] ADDR_FIRST_SLOT = 8'h22;
    localparam logic [7:0] ADDR_SECOND_SLOT = 8'h23;
    localparam logic [7:0] ADDR_BACKUP_SLOT = 8'h24;

    // Reset values
    localparam logic [7:0] RST_DELAY_FACTOR = 8'h00;
    localparam logic [7:0] RST_FIRST_SLOT = 8'h98;
    localparam logic [7:0] RST_SECOND_SLOT = 8'h75;
    localparam logic [7:0] RST_BACKUP_SLOT = 8'h12;
    localparam logic [7:0] RST_READ_DATA = 8'h00;

    // Writable bit masks; all other bits are reserved and read zero
    localparam logic [7:0] MASK_DELAY_FACTOR = 8'h81;
    localparam logic [7:0] MASK_BACKUP_SLOT = 8'h33;

    // Field positions
    localparam int POS_PD_FACTOR = 7;
    localparam int POS_NINTH_GAP = 0;
    localparam int POS_HI_SLOT = 4;
    localparam int POS_LO_SLOT = 0;
    localparam int POS_BKP_HI_SLOT = 4;
    localparam int POS_BKP_LO_SLOT = 0;

    // Strobe numbering
    localparam logic [3:0] STROBE_FIRST = 4'h1;
    localparam logic [3:0] STROBE_BACKUP_LAST = 4'h2;
    localparam logic [3:0] STROBE_MAIN_FIRST = 4'h3;
    localparam logic [3:0] STROBE_LAST = 4'ha;
    localparam logic [3:0] STROBE_NONE = 4'h0;
    localparam logic [3:0] GAP_NINTH = 4'h9;

    // Gap timing
    localparam int CLOCK_KHZ = 25000;
    localparam int GAP_SHORT_MS = 2;
    localparam int GAP_LONG_MS = 5;
    localparam int PD_SCALE = 10;
    localparam int GAP_CNT_W = 21;
endpackage

// file: rtl/rss_gap_timer.sv
// Down counter that times the gap between two strobes
`timescale 1ns/1ps
module rss_gap_timer
    import rss_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic load,
    input wire logic [GAP_CNT_W-1:0] load_cycles,
    output logic expired
);
    logic [GAP_CNT_W-1:0] remaining;

    // Count down from the loaded length
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            remaining <= '0;
        end else if (load) begin
            remaining <= load_cycles;
        end else if (remaining != '0) begin
            remaining <= remaining - 1'b1;
        end
    end

    // One-cycle pulse as the count reaches zero
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            expired <= 1'b0;
        end else begin
            expired <= !load && (remaining == GAP_CNT_W'(1));
        end
    end
endmodule

// file: rtl/rss_sequencer.sv
// Rail strobe sequencer with its configuration registers
`timescale 1ns/1ps
module rss_sequencer
    import rss_pkg::*;
#(
    parameter int SHORT_GAP_CYCLES = GAP_SHORT_MS * CLOCK_KHZ,
    parameter int LONG_GAP_CYCLES = GAP_LONG_MS * CLOCK_KHZ
)
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [7:0] strobe_gap_long,
    input wire logic freshness_seal_bit,
    input wire logic power_up_req,
    input wire logic power_down_req,
    output logic first_buck_rail_en,
    output logic second_buck_rail_en,
    output logic third_buck_rail_en,
    output logic buckboost_rail_en,
    output logic [1:0] backup_rail_en,
    output logic [3:0] active_strobe,
    output logic seq_busy
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_FIRE = 3'b010,
        ST_WAIT = 3'b100
    } rss_state_t;

    rss_state_t state;
    rss_state_t next_state;
    logic [7:0] delay_factor_reg;
    logic [7:0] first_slot_reg;
    logic [7:0] second_slot_reg;
    logic [7:0] backup_slot_reg;
    logic going_down;
    logic [3:0] strobe_idx;
    logic [3:0] next_strobe_idx;
    logic gap_load;
    logic gap_expired;
    logic gap_is_long;
    logic [GAP_CNT_W-1:0] gap_base;
    logic [GAP_CNT_W-1:0] gap_cycles;
    logic [3:0] gap_idx;
    logic last_strobe;
    logic backup_strobe_ok;
    logic [3:0] buck1_strobe_slot;
    logic [3:0] buck2_strobe_slot;
    logic [3:0] buck3_strobe_slot;
    logic [3:0] buckboost_strobe_slot;
    logic [1:0] backup_lo_slot;
    logic [1:0] backup_hi_slot;
    logic powerdown_delay_multiplier;
    logic ninth_strobe_gap;

    // Main rail slot hits only for values 3h through Ah
    function automatic logic main_slot_hit(input logic [3:0] slot, input logic [3:0] strobe);
        main_slot_hit = (slot >= STROBE_MAIN_FIRST) && (slot <= STROBE_LAST) && (slot == strobe);
    endfunction

    // Backup rail slot hits only for values 1h and 2h
    function automatic logic backup_slot_hit(input logic [1:0] slot, input logic [3:0] strobe);
        backup_slot_hit = (slot != 2'h0) && ({2'h0, slot} <= STROBE_BACKUP_LAST) && ({2'h0, slot} == strobe);
    endfunction

    // Field views of the registers
    assign powerdown_delay_multiplier = delay_factor_reg[POS_PD_FACTOR];
    assign ninth_strobe_gap = delay_factor_reg[POS_NINTH_GAP];
    assign buck1_strobe_slot = first_slot_reg[POS_LO_SLOT +: 4];
    assign buck2_strobe_slot = first_slot_reg[POS_HI_SLOT +: 4];
    assign buck3_strobe_slot = second_slot_reg[POS_LO_SLOT +: 4];
    assign buckboost_strobe_slot = second_slot_reg[POS_HI_SLOT +: 4];
    assign backup_lo_slot = backup_slot_reg[POS_BKP_LO_SLOT +: 2];
    assign backup_hi_slot = backup_slot_reg[POS_BKP_HI_SLOT +: 2];

    // Register writes; reserved bits are masked off
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            delay_factor_reg <= RST_DELAY_FACTOR;
            first_slot_reg <= RST_FIRST_SLOT;
            second_slot_reg <= RST_SECOND_SLOT;
            backup_slot_reg <= RST_BACKUP_SLOT;
        end else if (reg_wr) begin
            case (reg_addr)
                ADDR_DELAY_FACTOR: begin
                    delay_factor_reg <= reg_wdata & MASK_DELAY_FACTOR;
                end
                ADDR_FIRST_SLOT: begin
                    first_slot_reg <= reg_wdata;
                end
                ADDR_SECOND_SLOT: begin
                    second_slot_reg <= reg_wdata;
                end
                ADDR_BACKUP_SLOT: begin
                    backup_slot_reg <= reg_wdata & MASK_BACKUP_SLOT;
                end
                default: begin
                end
            endcase
        end
    end

    // Register reads answer one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= RST_READ_DATA;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                case (reg_addr)
                    ADDR_DELAY_FACTOR: reg_rdata <= delay_factor_reg;
                    ADDR_FIRST_SLOT: reg_rdata <= first_slot_reg;
                    ADDR_SECOND_SLOT: reg_rdata <= second_slot_reg;
                    ADDR_BACKUP_SLOT: reg_rdata <= backup_slot_reg;
                    default: reg_rdata <= RST_READ_DATA;
                endcase
            end
        end
    end

    // Gap that follows the current strobe: up uses strobe n, down uses n-1
    assign gap_idx = going_down ? (strobe_idx - 4'h1) : strobe_idx;
    assign gap_is_long = (gap_idx == GAP_NINTH) ? ninth_strobe_gap : strobe_gap_long[3'(gap_idx - 4'h1)];
    assign gap_base = gap_is_long ? GAP_CNT_W'(LONG_GAP_CYCLES) : GAP_CNT_W'(SHORT_GAP_CYCLES);

    // Scale only power-down gaps by the factor bit
    always_comb begin
        if (going_down && powerdown_delay_multiplier) begin
            gap_cycles = GAP_CNT_W'(gap_base * PD_SCALE);
        end else begin
            gap_cycles = gap_base;
        end
    end

    assign last_strobe = going_down ? (strobe_idx == STROBE_FIRST) : (strobe_idx == STROBE_LAST);
    assign backup_strobe_ok = !freshness_seal_bit;
    assign gap_load = (state == ST_FIRE) && !last_strobe;

    // Sequencer state transitions
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (power_up_req || power_down_req) begin
                    next_state = ST_FIRE;
                end
            end
            ST_FIRE: begin
                next_state = last_strobe ? ST_IDLE : ST_WAIT;
            end
            ST_WAIT: begin
                if (gap_expired) begin
                    next_state = ST_FIRE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Next strobe: first one of a new sequence, or one step on when the gap runs out
    always_comb begin
        next_strobe_idx = strobe_idx;
        if (state == ST_IDLE) begin
            if (power_up_req) begin
                next_strobe_idx = STROBE_FIRST;
            end else if (power_down_req) begin
                next_strobe_idx = STROBE_LAST;
            end
        end else if (state == ST_WAIT && gap_expired) begin
            next_strobe_idx = going_down ? (strobe_idx - 4'h1) : (strobe_idx + 4'h1);
        end
    end

    // Direction and strobe index; up wins when both requests come together
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            going_down <= 1'b0;
            strobe_idx <= STROBE_NONE;
        end else begin
            strobe_idx <= next_strobe_idx;
            if (state == ST_IDLE && (power_up_req || power_down_req)) begin
                going_down <= !power_up_req;
            end
        end
    end

    // Main rails switch on going up and off going down at their strobe
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            first_buck_rail_en <= 1'b0;
            second_buck_rail_en <= 1'b0;
            third_buck_rail_en <= 1'b0;
            buckboost_rail_en <= 1'b0;
        end else if (state == ST_FIRE) begin
            if (main_slot_hit(buck1_strobe_slot, strobe_idx)) first_buck_rail_en <= !going_down;
            if (main_slot_hit(buck2_strobe_slot, strobe_idx)) second_buck_rail_en <= !going_down;
            if (main_slot_hit(buck3_strobe_slot, strobe_idx)) third_buck_rail_en <= !going_down;
            if (main_slot_hit(buckboost_strobe_slot, strobe_idx)) buckboost_rail_en <= !going_down;
        end
    end

    // Backup rails follow strobes 1 and 2 only while freshness_seal_bit is clear
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            backup_rail_en <= 2'b00;
        end else if (state == ST_FIRE && backup_strobe_ok) begin
            if (backup_slot_hit(backup_lo_slot, strobe_idx)) backup_rail_en[0] <= !going_down;
            if (backup_slot_hit(backup_hi_slot, strobe_idx)) backup_rail_en[1] <= !going_down;
        end
    end

    // Status outputs
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            active_strobe <= STROBE_NONE;
            seq_busy <= 1'b0;
        end else begin
            // Shows the strobe of the coming cycle, so a new sequence reports its first strobe at once
            active_strobe <= (next_state == ST_IDLE) ? STROBE_NONE : next_strobe_idx;
            seq_busy <= (next_state != ST_IDLE);
        end
    end

    // Inter-strobe gap timer
    rss_gap_timer u_gap_timer (
        .clock(clock),
        .arst_n(arst_n),
        .load(gap_load),
        .load_cycles(gap_cycles),
        .expired(gap_expired)
    );
endmodule

// file: dv/rss_sequencer_props.sv
// Assertions on the sequencer register port and strobe outputs
`timescale 1ns/1ps
module rss_sequencer_props
    import rss_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic freshness_seal_bit,
    input wire logic power_up_req,
    input wire logic power_down_req,
    input wire logic first_buck_rail_en,
    input wire logic [1:0] backup_rail_en,
    input wire logic [3:0] active_strobe,
    input wire logic seq_busy
);
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    // Read answer timing and hold
    rd_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
    rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd)) else $error("stray read valid");
    rdata_hold_a: assert property (!$past(reg_rd) |-> $stable(reg_rdata)) else $error("read data moved");
    // Sequence start, stepping and idle
    up_start_a: assert property (!seq_busy && power_up_req |=> seq_busy && active_strobe == 4'h1)
        else $error("power-up start wrong");
    down_start_a: assert property (!seq_busy && power_down_req && !power_up_req |=> active_strobe == 4'ha)
        else $error("power-down start wrong");
    idle_strobe_a: assert property (!seq_busy |-> active_strobe == 4'h0) else $error("strobe while idle");
    strobe_step_a: assert property (seq_busy && $past(seq_busy) && $changed(active_strobe) |->
        active_strobe == $past(active_strobe) + 4'h1 || active_strobe == $past(active_strobe) - 4'h1)
        else $error("strobe skipped");
    gap_min_a: assert property (seq_busy && $changed(active_strobe) && active_strobe inside {[4'h2:4'h9]}
        |=> $stable(active_strobe) [*3]) else $error("gap too short");
    // First buck rail only moves inside a sequence; sealed backups stay put
    rail_quiet_a: assert property ($changed(first_buck_rail_en) |-> $past(seq_busy))
        else $error("rail moved while idle");
    seal_hold_a: assert property (freshness_seal_bit && $past(freshness_seal_bit) |-> $stable(backup_rail_en))
        else $error("sealed backup moved");
    up_c: cover property (!seq_busy && power_up_req);
    down_c: cover property (!seq_busy && power_down_req);
    read_c: cover property (reg_rvalid);
endmodule
bind rss_sequencer rss_sequencer_props rss_sequencer_props_inst (.clock, .arst_n, .reg_rd, .reg_rdata,
    .reg_rvalid, .freshness_seal_bit, .power_up_req, .power_down_req, .first_buck_rail_en, .backup_rail_en,
    .active_strobe, .seq_busy);

// file: dv/tb_top.sv
// Self-checking bench for the rail strobe sequencer
`timescale 1ns/1ps
module tb_top;
    import rss_pkg::*;
    localparam int SG = 4;
    localparam int LG = 7;
    // Reset starts unknown so that its first drive to zero is a real falling edge
    logic clock = 0, arst_n, reg_wr = 0, reg_rd = 0;
    logic freshness_seal_bit = 0, power_up_req = 0, power_down_req = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, strobe_gap_long = 8'h05, reg_rdata;
    logic reg_rvalid, first_buck_rail_en, second_buck_rail_en, third_buck_rail_en, buckboost_rail_en, seq_busy;
    logic [1:0] backup_rail_en;
    logic [3:0] active_strobe;
    logic [5:0] rails;
    logic [7:0] sh [8'h21:8'h24];
    logic [23:0] rows [6] = '{24'h21ff81, 24'h217e00, 24'h22a3a3, 24'h230b0b, 24'h24ff33, 24'h305500};
    int num_errors = 0, compares = 0, n;
    always #20 clock = ~clock;
    rss_sequencer #(.SHORT_GAP_CYCLES(SG), .LONG_GAP_CYCLES(LG)) rss_sequencer_inst (.clock, .arst_n, .reg_wr,
        .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .strobe_gap_long, .freshness_seal_bit,
        .power_up_req, .power_down_req, .first_buck_rail_en, .second_buck_rail_en, .third_buck_rail_en,
        .buckboost_rail_en, .backup_rail_en, .active_strobe, .seq_busy);
    assign rails = {first_buck_rail_en, second_buck_rail_en, third_buck_rail_en, buckboost_rail_en, backup_rail_en};
    // Compare, count and report
    task automatic check(logic [7:0] got, logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        if (num_errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Reset for six cycles and reload the shadow copy
    task automatic do_reset();
        arst_n = 0;
        repeat (6) @(posedge clock);
        #1 arst_n = 1;
        sh = '{RST_DELAY_FACTOR, RST_FIRST_SLOT, RST_SECOND_SLOT, RST_BACKUP_SLOT};
    endtask
    // Register write and read cycles
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clock) #1;
        reg_wr = 1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clock) #1;
        reg_wr = 0;
        if (a inside {[8'h21:8'h24]})
            sh[a] = d & (a == 8'h21 ? MASK_DELAY_FACTOR : a == 8'h24 ? MASK_BACKUP_SLOT : 8'hff);
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(posedge clock) #1;
        reg_rd = 1;
        reg_addr = a;
        @(posedge clock) #1;
        reg_rd = 0;
        check({7'h00, reg_rvalid}, 8'h01);
        check(reg_rdata, e);
    endtask
    // Gap length in cycles, and a rail's level after strobe k
    function automatic int gap(int k, logic dn);
        logic lg;
        lg = (k == 9) ? sh[8'h21][0] : strobe_gap_long[k-1];
        // A strobe stands for its fire cycle, the loaded count and the expiry cycle
        return (lg ? LG : SG) * ((dn && sh[8'h21][7]) ? 10 : 1) + 2;
    endfunction
    function automatic logic rail(logic v, logic [3:0] s, logic bk, int k, logic up);
        if (bk ? (freshness_seal_bit || s == 4'h0 || s == 4'h3) : (s < 4'h3 || s > 4'ha))
            return v;
        return up ? (s <= k ? 1'b1 : v) : (s >= k ? 1'b0 : v);
    endfunction
    // One full sequence: strobe order, dwell of each strobe, rails after it
    task automatic run_seq(logic up);
        int k;
        logic [5:0] v, e;
        v = rails;
        @(posedge clock) #1;
        power_up_req = up;
        power_down_req = !up;
        @(posedge clock) #1;
        power_up_req = 0;
        power_down_req = 0;
        for (int i = 0; i < 10; i++) begin
            k = up ? i + 1 : 10 - i;
            check({4'h0, active_strobe}, 8'(k));
            n = 0;
            do begin
                @(posedge clock) #1;
                n++;
            end while (active_strobe === 4'(k) && n < 1000);
            check(8'(n), 8'(i == 9 ? 1 : gap(up ? k : k - 1, !up)));
            if (n >= 1000)
                stop_test();
            e = {rail(v[5], sh[8'h22][3:0], 0, k, up), rail(v[4], sh[8'h22][7:4], 0, k, up),
                rail(v[3], sh[8'h23][3:0], 0, k, up), rail(v[2], sh[8'h23][7:4], 0, k, up),
                rail(v[1], {2'h0, sh[8'h24][5:4]}, 1, k, up), rail(v[0], {2'h0, sh[8'h24][1:0]}, 1, k, up)};
            check({2'h0, rails}, {2'h0, e});
        end
        check({7'h00, seq_busy}, 8'h00);
    endtask
    // Register table rows, reset values, then four sequences
    initial begin
        do_reset();
        foreach (rows[i]) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], rows[i][7:0]);
        end
        do_reset();
        rd(8'h21, 8'h00);
        rd(8'h22, 8'h98);
        rd(8'h23, 8'h75);
        rd(8'h24, 8'h12);
        wr(8'h22, 8'ha3);
        wr(8'h23, 8'h0b);
        wr(8'h21, 8'h81);
        run_seq(1);
        freshness_seal_bit = 1;
        run_seq(0);
        wr(8'h21, 8'h00);
        run_seq(1);
        run_seq(0);
        stop_test();
    end
endmodule
